// ==== multilevel_pipeline_params.svh ====
// Constants for the multilevel pipeline register: sizes, op codes,
// register offsets and field positions.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef MULTILEVEL_PIPELINE_PARAMS_SVH
`define MULTILEVEL_PIPELINE_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MLP_WORD_W        16
`define MLP_STAGES        8
`define MLP_PICK_W        3
`define MLP_OP_W          4

// ----------------------------------------------------------------
// Op codes
// ----------------------------------------------------------------
`define MLP_OP_LOAD_BIT   3
`define MLP_OP_CHAIN8     4'h8
`define MLP_OP_CHAIN_LO4  4'h9
`define MLP_OP_CHAIN_HI4  4'ha
`define MLP_OP_PAIR1      4'hb
`define MLP_OP_PAIR2      4'hc
`define MLP_OP_PAIR3      4'hd
`define MLP_OP_PAIR4      4'he
`define MLP_OP_HOLD       4'hf

// ----------------------------------------------------------------
// Stage masks of the shift chains
// ----------------------------------------------------------------
`define MLP_MASK_CHAIN8   8'hff
`define MLP_MASK_LO4      8'h0f
`define MLP_MASK_HI4      8'hf0
`define MLP_MASK_PAIR1    8'h03
`define MLP_MASK_PAIR2    8'h0c
`define MLP_MASK_PAIR3    8'h30
`define MLP_MASK_PAIR4    8'hc0
`define MLP_MASK_NONE     8'h00

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define MLP_ADDR_W        8
`define MLP_OFF_CTRL      8'h00
`define MLP_OFF_CMD       8'h04
`define MLP_OFF_STATUS    8'h08
`define MLP_OFF_PINS      8'h0c
`define MLP_OFF_STAGE0    8'h20
`define MLP_OFF_STAGE7    8'h3c

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MLP_CTRL_PIN_LOCK 0
`define MLP_CTRL_RESET    1'h0
`define MLP_CMD_OP_LSB    0
`define MLP_CMD_DATA_LSB  16
`define MLP_STAT_OP_LSB   0
`define MLP_STAT_MASK_LSB 8
`define MLP_STAT_CNT_LSB  16
`define MLP_CNT_W         16
`define MLP_CNT_RESET     16'h0000
`define MLP_LAST_OP_RESET 4'hf

`endif

// ==== multilevel_pipeline_pkg.sv ====
// Types and the chain decoder shared by the pipeline register files.
// Assumes the params header is on the include path.
`include "multilevel_pipeline_params.svh"

package multilevel_pipeline_pkg;

    typedef logic [`MLP_WORD_W-1:0]                  word_t;
    typedef logic [`MLP_STAGES-1:0][`MLP_WORD_W-1:0] bank_t;
    typedef logic [`MLP_STAGES-1:0]                  mask_t;

    // One operation as it reaches the stage bank
    typedef struct packed {
        logic                  valid;
        logic [`MLP_OP_W-1:0]  op;
        word_t                 data;
    } exec_t;

    // Stages touched by an op code; empty for hold
    function automatic mask_t op_mask(input logic [`MLP_OP_W-1:0] op);
        mask_t m;
        m = `MLP_MASK_NONE;
        if (!op[`MLP_OP_LOAD_BIT]) begin
            m[op[`MLP_PICK_W-1:0]] = 1'b1;
        end else begin
            case (op)
                `MLP_OP_CHAIN8:    m = `MLP_MASK_CHAIN8;
                `MLP_OP_CHAIN_LO4: m = `MLP_MASK_LO4;
                `MLP_OP_CHAIN_HI4: m = `MLP_MASK_HI4;
                `MLP_OP_PAIR1:     m = `MLP_MASK_PAIR1;
                `MLP_OP_PAIR2:     m = `MLP_MASK_PAIR2;
                `MLP_OP_PAIR3:     m = `MLP_MASK_PAIR3;
                `MLP_OP_PAIR4:     m = `MLP_MASK_PAIR4;
                default:           m = `MLP_MASK_NONE;
            endcase
        end
        return m;
    endfunction : op_mask

endpackage : multilevel_pipeline_pkg

// ==== stage_next.sv ====
// Next contents of the stage bank for one operation.
// Assumes a same-clock caller that registers the result.
`timescale 1ns/100ps
`include "multilevel_pipeline_params.svh"

module stage_next (
    input  multilevel_pipeline_pkg::bank_t cur,
    input  multilevel_pipeline_pkg::exec_t cmd,
    output multilevel_pipeline_pkg::bank_t nxt,
    output multilevel_pipeline_pkg::mask_t touched
);

    multilevel_pipeline_pkg::mask_t mask;
    multilevel_pipeline_pkg::mask_t head;

    // Idle cycles and hold touch nothing
    assign mask    = cmd.valid ? multilevel_pipeline_pkg::op_mask(cmd.op)
                               : `MLP_MASK_NONE;
    assign touched = mask;
    // Chain head: in the mask, predecessor not
    assign head    = mask & ~{mask[`MLP_STAGES-2:0], 1'b0};

    genvar i;
    generate
        for (i = 0; i < `MLP_STAGES; i = i + 1) begin : g_stage
            if (i == 0) begin : g_first
                assign nxt[i] = mask[i] ? cmd.data : cur[i];
            end else begin : g_rest
                // Head takes input, others take predecessor
                assign nxt[i] = !mask[i] ? cur[i] :
                                head[i]  ? cmd.data : cur[i-1];
            end
        end
    endgenerate

endmodule : stage_next

// ==== stage_pick_mux.sv ====
// Eight-to-one output selector with a driven flag.
// Assumes the bank is stable between clock edges.
`timescale 1ns/100ps
`include "multilevel_pipeline_params.svh"

module stage_pick_mux (
    input  multilevel_pipeline_pkg::bank_t  bank,
    input  wire logic [`MLP_PICK_W-1:0]     pick,
    input  wire logic                       output_enable_n,
    output multilevel_pipeline_pkg::word_t  word,
    output logic                            drive
);

    assign word  = bank[pick];
    assign drive = ~output_enable_n;

endmodule : stage_pick_mux

// ==== multilevel_pipeline_register.sv ====
// Eight stage, sixteen bit programmable pipeline register with an
// AHB-Lite side port for commands, status and stage readback.
// Assumes pin-side controls come from logic on hclk; the pad wire is
// resolved outside from data_out and data_out_oe.
`timescale 1ns/100ps
`include "multilevel_pipeline_params.svh"

module multilevel_pipeline_register (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // Pin side
    input  wire logic [`MLP_WORD_W-1:0]   data_in,
    input  wire logic [`MLP_OP_W-1:0]     op_code,
    input  wire logic [`MLP_PICK_W-1:0]   stage_pick,
    input  wire logic                     clock_enable_n,
    input  wire logic                     output_enable_n,
    output logic      [`MLP_WORD_W-1:0]   data_out,
    output logic                          data_out_oe,
    // AHB-Lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    multilevel_pipeline_pkg::bank_t  stage;
    multilevel_pipeline_pkg::bank_t  next_stage;
    multilevel_pipeline_pkg::mask_t  touched;
    multilevel_pipeline_pkg::exec_t  exec;
    multilevel_pipeline_pkg::word_t  pick_word;
    logic                            pick_drive;

    // ----------------------------------------------------------------
    // Bus state
    // ----------------------------------------------------------------
    logic                            pin_lock;
    logic [`MLP_OP_W-1:0]            last_op;
    multilevel_pipeline_pkg::mask_t  last_mask;
    logic [`MLP_CNT_W-1:0]           op_count;
    logic                            wr_pend;
    logic [`MLP_ADDR_W-1:0]          wr_addr;

    // ----------------------------------------------------------------
    // Address phase decode
    // ----------------------------------------------------------------
    wire                   take       = hsel & htrans[1] & hready;
    wire                   take_rd    = take & ~hwrite;
    wire                   take_wr    = take & hwrite;
    wire [`MLP_ADDR_W-1:0] a_addr     = haddr[`MLP_ADDR_W-1:0];
    wire                   a_in_page  = (haddr[31:`MLP_ADDR_W] == 24'h000000);
    wire                   a_is_stage = a_in_page &&
                                        (a_addr >= `MLP_OFF_STAGE0) &&
                                        (a_addr <= `MLP_OFF_STAGE7) &&
                                        (a_addr[1:0] == 2'h0);
    wire [`MLP_PICK_W-1:0] a_stage_ix = a_addr[`MLP_PICK_W+1:2];

    // ----------------------------------------------------------------
    // Data phase decode
    // ----------------------------------------------------------------
    wire wr_ctrl = wr_pend && (wr_addr == `MLP_OFF_CTRL);
    wire wr_cmd  = wr_pend && (wr_addr == `MLP_OFF_CMD);

    // ----------------------------------------------------------------
    // Read data for the address being taken
    // ----------------------------------------------------------------
    wire [31:0] rd_ctrl   = {31'h00000000, pin_lock};
    wire [31:0] rd_status = {op_count, last_mask, 4'h0, last_op};
    wire [31:0] rd_pins   = {data_in,
                             6'h00,
                             output_enable_n,
                             clock_enable_n,
                             1'h0,
                             stage_pick,
                             op_code};
    wire [31:0] rd_stage  = {16'h0000, stage[a_stage_ix]};
    wire [31:0] rd_value  = !a_in_page                   ? 32'h00000000 :
                            a_is_stage                   ? rd_stage     :
                            (a_addr == `MLP_OFF_CTRL)    ? rd_ctrl      :
                            (a_addr == `MLP_OFF_STATUS)  ? rd_status    :
                            (a_addr == `MLP_OFF_PINS)    ? rd_pins      :
                                                           32'h00000000;

    // ----------------------------------------------------------------
    // Operation source
    // ----------------------------------------------------------------
    // A bus command wins over the pins in its cycle, so software can
    // drive a locked bank without racing the datapath.
    wire                      pin_go   = ~clock_enable_n & ~pin_lock;
    wire [`MLP_OP_W-1:0]      cmd_op   = hwdata[`MLP_CMD_OP_LSB +: `MLP_OP_W];
    wire [`MLP_WORD_W-1:0]    cmd_data = hwdata[`MLP_CMD_DATA_LSB +: `MLP_WORD_W];

    assign exec.valid = wr_cmd | pin_go;
    assign exec.op    = wr_cmd ? cmd_op   : op_code;
    assign exec.data  = wr_cmd ? cmd_data : data_in;

    // ----------------------------------------------------------------
    // Stage bank
    // ----------------------------------------------------------------
    stage_next u_next (
        .cur     (stage),
        .cmd     (exec),
        .nxt     (next_stage),
        .touched (touched)
    );

    // No reset on the bank: power-up contents are whatever they are
    always_ff @(posedge hclk) begin
        stage <= next_stage;
    end

    // ----------------------------------------------------------------
    // Output port
    // ----------------------------------------------------------------
    // Select and enable act without the clock, so this path is the one
    // place where the output is not taken from a flip-flop.
    stage_pick_mux u_mux (
        .bank            (stage),
        .pick            (stage_pick),
        .output_enable_n (output_enable_n),
        .word            (pick_word),
        .drive           (pick_drive)
    );

    assign data_out    = pick_word;
    assign data_out_oe = pick_drive;

    // ----------------------------------------------------------------
    // Bus registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= `MLP_OFF_CTRL;
        end else begin
            wr_pend <= take_wr & a_in_page;
            wr_addr <= a_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_lock <= `MLP_CTRL_RESET;
        end else if (wr_ctrl) begin
            pin_lock <= hwdata[`MLP_CTRL_PIN_LOCK];
        end
    end

    // Status follows every operation that reached the bank
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_op   <= `MLP_LAST_OP_RESET;
            last_mask <= `MLP_MASK_NONE;
            op_count  <= `MLP_CNT_RESET;
        end else if (exec.valid) begin
            last_op   <= exec.op;
            last_mask <= touched;
            op_count  <= op_count + 16'h0001;
        end
    end

    // Zero wait states; the answer is registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= take_rd ? rd_value : 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule : multilevel_pipeline_register

// ==== pipe_checks_assertions.sv ====
// Concurrent checks on the pipeline register top-level ports.
// Assumes one clock and hreadyout looped back as hready.
`timescale 1ns/100ps
module pipe_checks (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [15:0] data_in,
    input wire logic [3:0]  op_code,
    input wire logic [2:0]  stage_pick,
    input wire logic        clock_enable_n,
    input wire logic        output_enable_n,
    input wire logic [15:0] data_out,
    input wire logic        data_out_oe,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic        wr_ph;
    logic [31:0] wr_a;
    logic        lock;
    logic        run;
    logic [2:0]  head;

    // Mirror of the lock bit, so pin ops can be told apart from refusals
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            wr_a  <= 32'h00000000;
            lock  <= 1'b0;
        end else begin
            wr_ph <= hsel & htrans[1] & hwrite & hreadyout;
            wr_a  <= haddr;
            if (wr_ph && wr_a == 32'h00000000) lock <= hwdata[0];
        end
    end
    // A bus command in the data phase wins over the pins
    assign run  = !clock_enable_n && !lock && !wr_ph;
    assign head = (op_code == 4'hc) ? 3'h2 : (op_code == 4'he) ? 3'h6 :
                  (op_code == 4'ha || op_code == 4'hd) ? 3'h4 : 3'h0;

    sequence s_kept;
        stage_pick == $past(stage_pick);
    endsequence
    sequence s_head;
        stage_pick == $past(head);
    endsequence

    AST_OE: assert property (data_out_oe == !output_enable_n)
        else $error("output enable does not follow its pin");
    AST_FREEZE: assert property ((clock_enable_n && !wr_ph) ##1 s_kept
        |-> data_out === $past(data_out)) else $error("stage changed while disabled");
    AST_HOLD: assert property ((!clock_enable_n && op_code == 4'hf && !wr_ph) ##1 s_kept
        |-> data_out === $past(data_out)) else $error("hold op changed a stage");
    AST_LOAD: assert property ((run && !op_code[3])
        ##1 stage_pick == $past(op_code[2:0])
        |-> data_out === $past(data_in)) else $error("single load missed its stage");
    AST_HEAD: assert property ((run && op_code[3] && op_code != 4'hf) ##1 s_head
        |-> data_out === $past(data_in)) else $error("chain head did not take input");
    AST_MOVE: assert property ((run && op_code == 4'h8 && stage_pick != 3'h7)
        ##1 stage_pick == $past(stage_pick) + 3'h1
        |-> data_out === $past(data_out)) else $error("chain did not move a stage on");
    AST_KEEP: assert property ((run && (op_code == 4'h9 && stage_pick[2] ||
        op_code == 4'ha && !stage_pick[2])) ##1 s_kept
        |-> data_out === $past(data_out)) else $error("half chain touched other half");
    AST_BUS_LOAD: assert property ((wr_ph && wr_a == 32'h00000004 && !hwdata[3])
        ##1 stage_pick == $past(hwdata[2:0])
        |-> data_out === $past(hwdata[31:16])) else $error("bus load missed its stage");
endmodule : pipe_checks

// ==== host_model.sv ====
// Host datapath model driving the pin side of the register bank.
// Assumes one drive call per cycle from the bench's main thread.
`timescale 1ns/100ps
module host_model (
    input  wire logic        hclk,
    input  wire logic [15:0] data_out,
    input  wire logic        data_out_oe,
    output logic      [15:0] data_in,
    output logic      [3:0]  op_code,
    output logic      [2:0]  stage_pick,
    output logic             clock_enable_n,
    output logic             output_enable_n,
    output wire logic [15:0] pad
);
    // Floats when not driven, so stale data cannot pass for a read
    assign pad = data_out_oe ? data_out : 16'hzzzz;
    initial begin
        data_in         = 16'h0000;
        op_code         = 4'hf;
        stage_pick      = 3'h0;
        clock_enable_n  = 1'b1;
        output_enable_n = 1'b1;
    end
    // Op and pick change together: write one stage, read another
    task automatic drive(input logic [3:0] op, input logic [15:0] d,
                         input logic [2:0] pk, input logic ce_n, input logic oe_n);
        @(posedge hclk);
        op_code         <= op;
        data_in         <= d;
        stage_pick      <= pk;
        clock_enable_n  <= ce_n;
        output_enable_n <= oe_n;
    endtask : drive
endmodule : host_model

// ==== tb.sv ====
// Self-checking bench: random pin ops against a stage model, plus bus.
// Assumes a single slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
module tb;
    logic        hclk, hresetn, hsel, hwrite, lock;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, r, rd;
    logic [31:0] seed = 32'h0001563f;
    wire  logic [31:0] hrdata;
    wire  logic        hreadyout, hresp, data_out_oe, clock_enable_n, output_enable_n;
    wire  logic [15:0] data_in, data_out, pad;
    wire  logic [3:0]  op_code;
    wire  logic [2:0]  stage_pick;
    multilevel_pipeline_pkg::bank_t bank;
    int n_mismatch = 0, cmp_count = 0, n_exec = 0, cyc = 0;

    multilevel_pipeline_register dut (.hclk(hclk), .hresetn(hresetn), .data_in(data_in),
        .op_code(op_code), .stage_pick(stage_pick), .clock_enable_n(clock_enable_n),
        .output_enable_n(output_enable_n), .data_out(data_out), .data_out_oe(data_out_oe),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    host_model host (.hclk(hclk), .data_out(data_out), .data_out_oe(data_out_oe),
        .data_in(data_in), .op_code(op_code), .stage_pick(stage_pick), .pad(pad),
        .clock_enable_n(clock_enable_n), .output_enable_n(output_enable_n));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic multilevel_pipeline_pkg::bank_t apply(
        input multilevel_pipeline_pkg::bank_t b, input logic [3:0] op, input logic [15:0] d);
        logic [2:0] f, l;
        case (op)
            4'h8: {f, l} = 6'h07;
            4'h9: {f, l} = 6'h03;
            4'ha: {f, l} = 6'h27;
            4'hb: {f, l} = 6'h01;
            4'hc: {f, l} = 6'h13;
            4'hd: {f, l} = 6'h25;
            4'he: {f, l} = 6'h37;
            4'hf: return b;
            default: {f, l} = {op[2:0], op[2:0]};
        endcase
        for (int j = 7; j > 0; j--) if (j > f && j <= l) b[j] = b[j-1];
        b[f] = d;
        return b;
    endfunction : apply
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic step(input logic [3:0] op, input logic [15:0] d, input logic [2:0] pk,
                        input logic ce_n, input logic oe_n);
        host.drive(op, d, pk, ce_n, oe_n);
        @(negedge hclk);
        check("pad", oe_n ? 32'h0000zzzz : {16'h0000, bank[pk]}, {16'h0000, pad});
        if (!ce_n && !lock) begin
            bank = apply(bank, op, d);
            n_exec++;
        end
    endtask : step
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Whole run is well under a thousand cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, lock, htrans, haddr, hwdata} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // Stages power up unknown, so fill all before random traffic
        for (int k = 0; k < 8; k++) begin
            r = xs();
            // Look at the stage loaded one edge earlier, not the unknown one
            step(4'(k), r[15:0], 3'(k - 1), 1'b0, 1'b0);
        end
        $display("test fill done");
        for (int i = 0; i < 400; i++) begin
            r = xs();
            step(r[3:0], r[31:16], r[6:4], &r[9:8], &r[11:10]);
        end
        $display("test random ops done");
        step(4'h0, 16'h0000, 3'h3, 1'b1, 1'b0);
        bus(1'b0, 32'h00000080, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, 32'h00000000, 32'h1);
        lock = 1'b1;
        for (int i = 0; i < 20; i++) begin
            r = xs();
            step(r[3:0], r[31:16], r[6:4], 1'b0, 1'b0);
        end
        step(4'h0, 16'h0000, 3'h3, 1'b1, 1'b0);
        bus(1'b0, 32'h00000000, 32'h0);
        check("ctrl", 32'h1, rd);
        bus(1'b1, 32'h00000000, 32'h0);
        lock = 1'b0;
        $display("test lock done");
        r = xs();
        bus(1'b1, 32'h00000004, {r[31:16], 12'h000, 4'h8});
        bank = apply(bank, 4'h8, r[31:16]);
        bus(1'b1, 32'h00000004, {r[15:0], 12'h000, 4'h3});
        bank = apply(bank, 4'h3, r[15:0]);
        n_exec += 2;
        bus(1'b0, 32'h00000008, 32'h0);
        check("status", {n_exec[15:0], 8'h08, 8'h03}, rd);
        // Pins still stand as the last idle step left them
        bus(1'b0, 32'h0000000c, 32'h0);
        check("pins", 32'h00000130, rd);
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, 32'h00000020 + 32'(4 * k), 32'h0);
            check("stage", {16'h0000, bank[k]}, rd);
        end
        $display("test bus done");
        end_of_test();
    end
endmodule : tb

bind multilevel_pipeline_register pipe_checks chk (.hclk(hclk), .hresetn(hresetn),
    .data_in(data_in), .op_code(op_code), .stage_pick(stage_pick),
    .clock_enable_n(clock_enable_n), .output_enable_n(output_enable_n),
    .data_out(data_out), .data_out_oe(data_out_oe), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout));
